/* File: rtl/pin_select_pkg.sv */
// constants, field layouts and carrier types of the control mode pin select block
// How it works
// - driven mode pin selects pin-controlled mode
// - pin mode: serial off, settings from pins
// - mode pin low 600mV, high 800mV range
// - edge pin low negative, high positive edge
// - floating edge pin gives double data rate
// - floating mode pin selects serial control mode
// - serial mode: clock, data, select pins repurposed
package pin_select_pkg;

  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned FILT_W       = 8;
  localparam int unsigned COUNT_W      = 16;

  localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
  localparam logic [7:0]  FILTER_OFFSET  = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h08;
  localparam logic [7:0]  SCLK_OFFSET    = 8'h0c;
  localparam logic [7:0]  CHANGES_OFFSET = 8'h10;
  localparam logic [7:0]  PINS_OFFSET    = 8'h14;

  localparam int unsigned CTRL_RANGE_BIT = 0;
  localparam int unsigned CTRL_EDGE_BIT  = 1;
  localparam int unsigned CTRL_DDR_BIT   = 2;
  localparam int unsigned CTRL_SWING_BIT = 3;
  localparam int unsigned CTRL_W         = 4;
  localparam int unsigned STAT_SEL_BIT   = 5;
  localparam int unsigned STAT_CHG_BIT   = 8;

  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [7:0]  FILTER_RESET   = 8'h04;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // strap pin levels and whether the mode and edge pins are actively driven
  typedef struct packed {
    logic mode_level;
    logic mode_driven;
    logic edge_level;
    logic edge_driven;
    logic swing_level;
  } strap_s;

  // decoded configuration
  typedef struct packed {
    logic serial_mode;
    logic full_scale_high;
    logic output_edge_select;
    logic ddr;
    logic swing_high;
  } cfg_s;

  localparam int unsigned STRAP_W = $bits(strap_s);
  localparam int unsigned CFG_W   = $bits(cfg_s);

  typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} wr_state_e;
  typedef enum logic [0:0] {R_IDLE = 1'b0, R_DATA = 1'b1} rd_state_e;

endpackage

/* File: rtl/strap_filter.sv */
// stability filter: a strap level is taken once it has held for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module strap_filter
  import pin_select_pkg::*;
#(
  parameter int unsigned WIDTH = STRAP_W,
  parameter int unsigned CNT_W = FILT_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] raw,
  input  wire logic [CNT_W-1:0] stable_len,
  output var  logic [WIDTH-1:0] filt
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CNT_W-1:0] cnt;
      logic             held;
      wire              differs = raw[i] != held;
      wire              settled = cnt >= stable_len;
      // one process per bit with its own level and counter, so each process drives its own variables
      assign filt[i] = held;
      always_ff @(posedge clk) begin
        if (srst) begin
          held <= 1'b0;
          cnt  <= '0;
        end else if (!differs) begin
          cnt <= '0;
        end else if (settled) begin
          held <= raw[i];
          cnt  <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: rtl/serial_port_gate.sv */
// serial pin gating: passes clock, data and select only in serial mode, counts rising clock edges while select is active
`timescale 1ns/1ps
`default_nettype none
module serial_port_gate
  import pin_select_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               serial_mode,
  input  wire logic               sclk_raw,
  input  wire logic               serial_if_data_raw,
  input  wire logic               select_raw_n,
  input  wire logic               count_clear,
  output logic                    serial_if_clk,
  output logic                    serial_if_data,
  output logic                    serial_if_select,
  output logic [COUNT_W-1:0]      sclk_count
);

  // outside serial mode every serial output is held low
  wire next_clk    = serial_mode & sclk_raw;
  wire next_data   = serial_mode & serial_if_data_raw;
  wire next_select = serial_mode & ~select_raw_n;
  wire clk_rise    = next_clk & ~serial_if_clk & next_select;

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_if_clk    <= 1'b0;
      serial_if_data   <= 1'b0;
      serial_if_select <= 1'b0;
    end else begin
      serial_if_clk    <= next_clk;
      serial_if_data   <= next_data;
      serial_if_select <= next_select;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || count_clear) begin
      sclk_count <= '0;
    end else if (clk_rise) begin
      sclk_count <= sclk_count + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/control_mode_pin_select.sv */
// top: strap decode into pin or serial control mode, with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module control_mode_pin_select
  import pin_select_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  // strap pins; edge level doubles as serial data, swing level as serial clock
  input  wire strap_s            strap_pins,
  input  wire logic              select_pin_n,
  // decoded configuration
  output cfg_s                   cfg,
  output logic                   serial_if_clk,
  output logic                   serial_if_data,
  output logic                   serial_if_select,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  logic [CTRL_W-1:0]  ctrl;
  logic [FILT_W-1:0]  filter_len;
  logic               changed;
  logic [7:0]         change_count;
  logic [COUNT_W-1:0] sclk_count;
  wr_state_e          wr_state;
  rd_state_e          rd_state;
  logic               aw_hold;
  logic               w_hold;
  logic [ADDR_W-1:0]  aw_addr_q;
  logic [DATA_W-1:0]  w_data_q;
  logic [3:0]         w_strb_q;

  // strap filtering

  strap_s strap_f;
  logic [STRAP_W-1:0] strap_f_bits;

  strap_filter #(
    .WIDTH (STRAP_W),
    .CNT_W (FILT_W)
  ) u_filter (
    .clk        (clk),
    .srst       (srst),
    .raw        (strap_pins),
    .stable_len (filter_len),
    .filt       (strap_f_bits)
  );

  assign strap_f = strap_f_bits;

  // mode and setting decode

  wire serial_now = ~strap_f.mode_driven;
  wire pin_range  = strap_f.mode_level;
  wire pin_ddr    = ~strap_f.edge_driven;
  wire pin_edge   = strap_f.edge_driven & strap_f.edge_level;
  wire pin_swing  = strap_f.swing_level;

  cfg_s next_cfg;
  assign next_cfg.serial_mode        = serial_now;
  assign next_cfg.full_scale_high    = serial_now ? ctrl[CTRL_RANGE_BIT] : pin_range;
  assign next_cfg.output_edge_select = serial_now ? ctrl[CTRL_EDGE_BIT] : pin_edge;
  assign next_cfg.ddr                = serial_now ? ctrl[CTRL_DDR_BIT] : pin_ddr;
  assign next_cfg.swing_high         = serial_now ? ctrl[CTRL_SWING_BIT] : pin_swing;

  wire cfg_change = next_cfg != cfg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // serial pins, gated by the registered mode

  wire sclk_clear;

  serial_port_gate u_gate (
    .clk              (clk),
    .srst             (srst),
    .serial_mode      (cfg.serial_mode),
    .sclk_raw         (strap_pins.swing_level),
    .serial_if_data_raw        (strap_pins.edge_level),
    .select_raw_n     (select_pin_n),
    .count_clear      (sclk_clear),
    .serial_if_clk    (serial_if_clk),
    .serial_if_data   (serial_if_data),
    .serial_if_select (serial_if_select),
    .sclk_count       (sclk_count)
  );

  // axi write channel

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire next_aw_hold = aw_hold | aw_fire;
  wire next_w_hold  = w_hold | w_fire;
  wire do_write = (wr_state == W_IDLE) & next_aw_hold & next_w_hold;
  wire b_fire   = s_axi_bvalid & s_axi_bready;

  wire [ADDR_W-1:0] wr_addr = aw_fire ? s_axi_awaddr : aw_addr_q;
  wire [DATA_W-1:0] wr_data = w_fire ? s_axi_wdata : w_data_q;
  wire [3:0]        wr_strb = w_fire ? s_axi_wstrb : w_strb_q;

  wire wr_ctrl    = do_write & (wr_addr == CTRL_OFFSET);
  wire wr_filter  = do_write & (wr_addr == FILTER_OFFSET);
  wire wr_status  = do_write & (wr_addr == STATUS_OFFSET);
  wire wr_sclk    = do_write & (wr_addr == SCLK_OFFSET);
  wire wr_changes = do_write & (wr_addr == CHANGES_OFFSET);
  wire wr_pins    = do_write & (wr_addr == PINS_OFFSET);
  wire wr_mapped  = wr_ctrl | wr_filter | wr_status | wr_sclk | wr_changes | wr_pins;

  assign sclk_clear = wr_sclk & wr_strb[0];

  wire chg_clear = wr_status & wr_strb[1] & wr_data[STAT_CHG_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      aw_hold <= next_aw_hold & ~do_write;
      w_hold  <= next_w_hold & ~do_write;
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_state      <= W_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      unique case (wr_state)
        W_IDLE: begin
          s_axi_awready <= ~next_aw_hold & ~do_write;
          s_axi_wready  <= ~next_w_hold & ~do_write;
          if (do_write) begin
            wr_state     <= W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        W_RESP: begin
          if (b_fire) begin
            wr_state      <= W_IDLE;
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= ~aw_hold;
            s_axi_wready  <= ~w_hold;
          end
        end
      endcase
    end
  end

  // software registers

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl       <= CTRL_RESET;
      filter_len <= FILTER_RESET;
    end else begin
      if (wr_ctrl && wr_strb[0]) begin
        ctrl <= wr_data[CTRL_W-1:0];
      end
      if (wr_filter && wr_strb[0]) begin
        filter_len <= wr_data[FILT_W-1:0];
      end
    end
  end

  // change flag: a new change wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      changed <= 1'b0;
    end else if (cfg_change) begin
      changed <= 1'b1;
    end else if (chg_clear) begin
      changed <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      change_count <= '0;
    end else if (wr_changes && wr_strb[0]) begin
      change_count <= '0;
    end else if (cfg_change && change_count != 8'hff) begin
      change_count <= change_count + 8'h01;
    end
  end

  // axi read channel

  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire r_fire  = s_axi_rvalid & s_axi_rready;

  wire [DATA_W-1:0] status_word = {
    {(DATA_W - STAT_CHG_BIT - 1){1'b0}},
    changed,
    {(STAT_CHG_BIT - STAT_SEL_BIT - 1){1'b0}},
    serial_if_select,
    cfg
  };

  logic [DATA_W-1:0] rd_word;
  logic              rd_ok;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFFSET:    rd_word[CTRL_W-1:0]  = ctrl;
      FILTER_OFFSET:  rd_word[FILT_W-1:0]  = filter_len;
      STATUS_OFFSET:  rd_word              = status_word;
      SCLK_OFFSET:    rd_word[COUNT_W-1:0] = sclk_count;
      CHANGES_OFFSET: rd_word[7:0]         = change_count;
      PINS_OFFSET:    rd_word[STRAP_W-1:0] = strap_f_bits;
      default:        rd_ok                = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_state      <= R_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      unique case (rd_state)
        R_IDLE: begin
          s_axi_arready <= ~ar_fire;
          if (ar_fire) begin
            rd_state     <= R_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        R_DATA: begin
          if (r_fire) begin
            rd_state      <= R_IDLE;
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: verif/control_mode_pin_select_checker.sv */
// concurrent checks on the control mode pin select ports
`timescale 1ns/1ps
`default_nettype none
module control_mode_pin_select_checker
  import pin_select_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire strap_s strap_pins,
  input  wire logic   select_pin_n,
  input  wire cfg_s   cfg,
  input  wire logic   serial_if_clk,
  input  wire logic   serial_if_data,
  input  wire logic   serial_if_select,
  input  wire logic   s_axi_bvalid,
  input  wire logic   s_axi_bready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_pin_serial_off: assert property (!cfg.serial_mode [*2] |->
    !serial_if_clk && !serial_if_data && !serial_if_select) else $error("serial active in pin mode");
  a_serial_follow: assert property (cfg.serial_mode [*2] |->
    serial_if_clk == $past(strap_pins.swing_level) && serial_if_data == $past(strap_pins.edge_level))
    else $error("serial clock or data not passed");
  a_serial_select: assert property (cfg.serial_mode [*2] |->
    serial_if_select == !$past(select_pin_n)) else $error("serial select not passed");
  a_float_serial: assert property (!strap_pins.mode_driven [*8] |->
    cfg.serial_mode) else $error("floating mode pin not serial");
  a_driven_pin: assert property (strap_pins.mode_driven [*8] |->
    !cfg.serial_mode) else $error("driven mode pin not pin mode");
  a_range_sel: assert property ((strap_pins.mode_driven && $stable(strap_pins.mode_level)) [*8] |->
    cfg.full_scale_high == strap_pins.mode_level) else $error("range does not follow pin");
  a_edge_sel: assert property
    ((strap_pins.mode_driven && strap_pins.edge_driven && $stable(strap_pins.edge_level)) [*8]
    |-> !cfg.ddr && cfg.output_edge_select == strap_pins.edge_level) else $error("edge wrong");
  a_ddr_float: assert property ((strap_pins.mode_driven && !strap_pins.edge_driven) [*8] |->
    cfg.ddr) else $error("floating edge pin not ddr");

  c_serial_clock: cover property (serial_if_select && $rose(serial_if_clk));
  c_pin_ddr: cover property (cfg.ddr && !cfg.serial_mode);
  c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind control_mode_pin_select control_mode_pin_select_checker i_control_mode_pin_select_checker (.*);
`default_nettype wire

/* File: verif/strap_host_model.sv */
// board strap and serial host model driving the control pins
`timescale 1ns/1ps
`default_nettype none
module strap_host_model
  import pin_select_pkg::*;
(
  input  wire logic clk,
  input  wire logic mode_float,
  input  wire logic mode_hi,
  input  wire logic edge_float,
  input  wire logic edge_hi,
  input  wire logic swing_hi,
  input  wire logic noise,
  output var strap_s strap_pins,
  output var logic   select_pin_n
);
  logic wander = 1'b0;
  logic sclk   = 1'b0;
  logic sdat   = 1'b0;
  logic sel_n  = 1'b1;
  always @(posedge clk) wander <= ~wander;
  // floating or released lines wander instead of holding a level
  assign strap_pins = '{mode_driven: !mode_float,
    mode_level: mode_float ? wander : mode_hi, edge_driven: mode_float | !edge_float,
    edge_level: mode_float ? (sel_n ? wander : sdat) : (edge_float ? wander : edge_hi),
    swing_level: mode_float ? sclk : (noise ? wander : swing_hi)};
  assign select_pin_n = mode_float ? sel_n : (noise ? wander : 1'b1);
  task automatic burst(input int n);
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (n) begin
      @(posedge clk);
      sclk <= 1'b1;
      sdat <= ~sdat;
      repeat (2) @(posedge clk);
      sclk <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
    sel_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verif/control_mode_pin_select_tb.sv */
// self-checking bench for the control mode pin select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module control_mode_pin_select_tb
  import pin_select_pkg::*;
;
  logic              clk, srst, select_pin_n, serial_if_clk, serial_if_data, serial_if_select;
  strap_s            strap_pins;
  cfg_s              cfg;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb, c;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              mode_float, mode_hi, edge_float, edge_hi, swing_hi, noise;
  int                n_errors = 0;
  int                cmp_count = 0;
  int                seed, n;

  control_mode_pin_select i_control_mode_pin_select (.*);
  strap_host_model i_strap_host_model (.clk(clk), .mode_float(mode_float), .mode_hi(mode_hi),
    .edge_float(edge_float), .edge_hi(edge_hi), .swing_hi(swing_hi), .noise(noise),
    .strap_pins(strap_pins), .select_pin_n(select_pin_n));

  always #20 clk = ~clk;

  function automatic cfg_s exp_cfg();
    if (mode_float) return '{1'b1, c[0], c[1], c[2], c[3]};
    return '{1'b0, mode_hi, !edge_float && edge_hi, edge_float, swing_hi};
  endfunction

  task automatic settle();
    repeat (10) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] e);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    seed = 96;
    clk = 1'b0;
    srst = 1'b1;
    c = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {mode_float, mode_hi, edge_float, edge_hi, swing_hi, noise} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(FILTER_OFFSET);
    `CHK("filter", {24'h0, FILTER_RESET}, d)
    rd(CTRL_OFFSET);
    `CHK("ctrl", 32'h0, d)
    rd(8'h40);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h40, 32'h5, 4'hf, RESP_SLVERR);
    wr(FILTER_OFFSET, 32'h3, 4'h1, RESP_OKAY);
    rd(FILTER_OFFSET);
    `CHK("filter", 32'h3, d)
    for (int i = 0; i < 8; i++) begin
      {edge_hi, edge_float, mode_hi} <= i[2:0];
      swing_hi <= 1'($random(seed));
      settle();
      `CHK("cfg", exp_cfg(), cfg)
      rd(STATUS_OFFSET);
      `CHK("status", exp_cfg(), d[4:0])
    end
    wr(SCLK_OFFSET, 32'h0, 4'hf, RESP_OKAY);
    noise <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("select", 1'b0, serial_if_select)
    noise <= 1'b0;
    rd(SCLK_OFFSET);
    `CHK("sclk count", 32'h0, d)
    mode_float <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      c = 4'($random(seed));
      wr(CTRL_OFFSET, {28'h0, c}, 4'h1, RESP_OKAY);
      settle();
      `CHK("cfg", exp_cfg(), cfg)
      wr(SCLK_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      n = (k == 0) ? 1 : 2 + {$random(seed)} % 7;
      i_strap_host_model.burst(n);
      rd(SCLK_OFFSET);
      `CHK("sclk count", 32'(n), d)
    end
    rd(STATUS_OFFSET);
    `CHK("changed", 1'b1, d[STAT_CHG_BIT])
    wr(STATUS_OFFSET, 32'h100, 4'h2, RESP_OKAY);
    rd(STATUS_OFFSET);
    `CHK("changed", 1'b0, d[STAT_CHG_BIT])
    results();
  end
endmodule
`default_nettype wire
